// [common/dse_pkg.sv]
// Purpose: shared constants and types for the security erase and freeze command block
// Assumes: one clock domain, register port with one-cycle read latency
// Notes: opcodes and task-file bit positions follow the drive's command set

package dse_pkg;
   // command opcodes
   localparam logic [7:0] DSE_OP_SET_PW = 8'hf1;
   localparam logic [7:0] DSE_OP_UNLOCK = 8'hf2;
   localparam logic [7:0] DSE_OP_PREPARE = 8'hf3;
   localparam logic [7:0] DSE_OP_ERASE = 8'hf4;
   localparam logic [7:0] DSE_OP_FREEZE = 8'hf5;
   localparam logic [7:0] DSE_OP_DIS_PW = 8'hf6;
   localparam logic [7:0] DSE_OP_FORMAT = 8'h50;

   // parameter sector layout, in 16-bit words
   localparam logic [7:0] DSE_WORD_CTRL = 8'h00;
   localparam logic [7:0] DSE_WORD_PW_FIRST = 8'h01;
   localparam logic [7:0] DSE_WORD_LAST = 8'hff;
   localparam int DSE_PW_WORDS = 16;
   localparam int DSE_PW_BITS = 256;
   localparam int DSE_CTRL_MASTER = 0;
   localparam int DSE_CTRL_ENHANCED = 1;

   // task-file status and error values
   localparam logic [7:0] DSE_ST_READY = 8'h50;
   localparam logic [7:0] DSE_ST_ERROR = 8'h51;
   localparam logic [7:0] DSE_ST_DRQ = 8'h58;
   localparam logic [7:0] DSE_ST_BUSY = 8'h80;
   localparam logic [7:0] DSE_ERR_NONE = 8'h00;
   localparam logic [7:0] DSE_ERR_ABORT = 8'h04;

   // register map, word offsets on the register port
   localparam logic [3:0] DSE_REG_CTRL = 4'h0;
   localparam logic [3:0] DSE_REG_STATE = 4'h1;
   localparam logic [3:0] DSE_REG_INT_STATUS = 4'h2;
   localparam logic [3:0] DSE_REG_INT_CLEAR = 4'h3;
   localparam logic [3:0] DSE_REG_INT_ENABLE = 4'h4;
   localparam logic [3:0] DSE_REG_PROGRESS = 4'h5;
   localparam int DSE_CTRL_LOCK_BIT = 0;

   // interrupt event bits
   localparam int DSE_INT_W = 4;
   localparam int DSE_EV_DONE = 0;
   localparam int DSE_EV_ABORT = 1;
   localparam int DSE_EV_FROZEN = 2;
   localparam int DSE_EV_ARMED = 3;
   localparam logic [3:0] DSE_INT_RESET = 4'h0;

   localparam int DSE_LBA_W = 28;

   typedef enum logic [2:0] {
      DSE_IDLE = 3'b001,
      DSE_XFER = 3'b010,
      DSE_ERASE = 3'b100
   } dse_state_t;
endpackage

// [core/dse_core.sv]
// Purpose: erase-prepare, erase-unit and freeze-lock command handling
// Assumes: command and data strobes come from same-clock task-file logic
// Notes: stored passwords arrive from the password store; media writes by handshake
//
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/100ps

module dse_core #(
   parameter logic [27:0] NATIVE_MAX_LBA = 28'h00fffff,
   parameter logic [15:0] ERASE_TIME_WORD = 16'h003c
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic cmd_wr,
   input wire logic [7:0] command_code,
   input wire logic data_wr,
   input wire logic [15:0] data_word,
   input wire logic [255:0] user_pw,
   input wire logic [255:0] master_pw,
   output logic [7:0] drive_status,
   output logic [7:0] error_flags,
   output logic zero_wr_valid,
   output logic [27:0] zero_wr_lba,
   input wire logic zero_wr_ack,
   output logic fwd_valid,
   output logic [7:0] fwd_code,
   output logic fwd_armed,
   output logic [15:0] ident_word89,
   output logic frozen,
   output logic lock_enabled,
   output logic irq
);

   dse_pkg::dse_state_t state;
   dse_pkg::dse_state_t next_state;
   logic armed;
   logic next_armed;
   logic next_frozen;
   logic next_lock;
   logic [7:0] word_idx;
   logic [15:0] ctrl_word;
   logic [15:0] pw_word [dse_pkg::DSE_PW_WORDS];
   logic [27:0] lba;
   logic [27:0] next_lba;
   logic [7:0] next_status;
   logic [7:0] next_error;
   logic [3:0] int_status;
   logic [3:0] int_enable;
   logic [3:0] events;

   // command decode
   wire logic in_idle = (state == dse_pkg::DSE_IDLE);
   wire logic in_xfer = (state == dse_pkg::DSE_XFER);
   wire logic in_erase = (state == dse_pkg::DSE_ERASE);
   wire logic new_cmd = cmd_wr & in_idle;
   wire logic op_prepare = (command_code == dse_pkg::DSE_OP_PREPARE);
   wire logic op_erase = (command_code == dse_pkg::DSE_OP_ERASE);
   wire logic op_freeze = (command_code == dse_pkg::DSE_OP_FREEZE);
   wire logic op_format = (command_code == dse_pkg::DSE_OP_FORMAT);
   wire logic op_lock_change = (command_code == dse_pkg::DSE_OP_SET_PW) | (command_code == dse_pkg::DSE_OP_UNLOCK) |
      (command_code == dse_pkg::DSE_OP_DIS_PW) | op_erase;
   wire logic frozen_reject = new_cmd & frozen & op_lock_change;

   // parameter sector assembly
   wire logic word_in = data_wr & in_xfer;
   wire logic sector_end = word_in & (word_idx == dse_pkg::DSE_WORD_LAST);
   wire logic ctrl_in = word_in & (word_idx == dse_pkg::DSE_WORD_CTRL);
   logic [255:0] given_pw;

   genvar gi;
   generate
      for (gi = 0; gi < dse_pkg::DSE_PW_WORDS; gi++) begin : g_pw
         assign given_pw[gi*16 +: 16] = pw_word[gi];
         always_ff @(posedge ref_clk) begin
            if (rst) begin
               pw_word[gi] <= 16'h0000;
            end else if (word_in && word_idx == dse_pkg::DSE_WORD_PW_FIRST + 8'(gi)) begin
               pw_word[gi] <= data_word;
            end
         end
      end
   endgenerate

   // control word as captured from word 0, held for the whole sector
   wire logic [15:0] ctrl_now = ctrl_word;
   wire logic [255:0] ref_pw = ctrl_now[dse_pkg::DSE_CTRL_MASTER] ? master_pw : user_pw;
   wire logic pw_bad = lock_enabled & (given_pw != ref_pw);
   wire logic mode_bad = ctrl_now[dse_pkg::DSE_CTRL_ENHANCED];
   wire logic sector_bad = pw_bad | mode_bad;

   // erase walk
   wire logic wr_done = in_erase & zero_wr_valid & zero_wr_ack;
   wire logic last_lba = (lba == NATIVE_MAX_LBA);
   wire logic erase_finish = wr_done & last_lba;

   // register port decode
   wire logic wr_ctrl = reg_wr & (reg_addr == dse_pkg::DSE_REG_CTRL);
   wire logic wr_clear = reg_wr & (reg_addr == dse_pkg::DSE_REG_INT_CLEAR);
   wire logic wr_enable = reg_wr & (reg_addr == dse_pkg::DSE_REG_INT_ENABLE);
   wire logic [31:0] state_word = {28'h0000000, in_erase | in_xfer, lock_enabled, armed, frozen};
   wire logic [31:0] rd_mux =
      (reg_addr == dse_pkg::DSE_REG_CTRL) ? {31'h0000000, lock_enabled} :
      (reg_addr == dse_pkg::DSE_REG_STATE) ? state_word :
      (reg_addr == dse_pkg::DSE_REG_INT_STATUS) ? {28'h0000000, int_status} :
      (reg_addr == dse_pkg::DSE_REG_INT_ENABLE) ? {28'h0000000, int_enable} :
      (reg_addr == dse_pkg::DSE_REG_PROGRESS) ? {4'h0, lba} : 32'h00000000;

   // command sequencer
   always_comb begin
      next_state = state;
      next_armed = armed;
      next_frozen = frozen;
      next_lock = lock_enabled;
      next_lba = lba;
      next_status = drive_status;
      next_error = error_flags;
      events = 4'h0;
      if (wr_ctrl) begin
         next_lock = reg_wdata[dse_pkg::DSE_CTRL_LOCK_BIT];
      end
      case (state)
         dse_pkg::DSE_IDLE: begin
            if (new_cmd) begin
               next_armed = 1'b0;
               next_status = dse_pkg::DSE_ST_READY;
               next_error = dse_pkg::DSE_ERR_NONE;
               if (frozen_reject) begin
                  next_status = dse_pkg::DSE_ST_ERROR;
                  next_error = dse_pkg::DSE_ERR_ABORT;
                  events[dse_pkg::DSE_EV_ABORT] = 1'b1;
               end else if (op_prepare) begin
                  next_armed = 1'b1;
                  events[dse_pkg::DSE_EV_ARMED] = 1'b1;
               end else if (op_freeze) begin
                  next_frozen = 1'b1;
                  events[dse_pkg::DSE_EV_FROZEN] = 1'b1;
               end else if (op_erase && !armed) begin
                  next_status = dse_pkg::DSE_ST_ERROR;
                  next_error = dse_pkg::DSE_ERR_ABORT;
                  events[dse_pkg::DSE_EV_ABORT] = 1'b1;
               end else if (op_erase) begin
                  next_state = dse_pkg::DSE_XFER;
                  next_status = dse_pkg::DSE_ST_DRQ;
               end
            end
         end
         dse_pkg::DSE_XFER: begin
            if (sector_end && sector_bad) begin
               next_state = dse_pkg::DSE_IDLE;
               next_status = dse_pkg::DSE_ST_ERROR;
               next_error = dse_pkg::DSE_ERR_ABORT;
               events[dse_pkg::DSE_EV_ABORT] = 1'b1;
            end else if (sector_end) begin
               next_state = dse_pkg::DSE_ERASE;
               next_status = dse_pkg::DSE_ST_BUSY;
               next_lba = 28'h0000000;
            end
         end
         dse_pkg::DSE_ERASE: begin
            if (erase_finish) begin
               next_state = dse_pkg::DSE_IDLE;
               next_status = dse_pkg::DSE_ST_READY;
               next_error = dse_pkg::DSE_ERR_NONE;
               next_lock = 1'b0;
               events[dse_pkg::DSE_EV_DONE] = 1'b1;
            end else if (wr_done) begin
               next_lba = lba + 28'h0000001;
            end
         end
         default: begin
            next_state = dse_pkg::DSE_IDLE;
         end
      endcase
   end

   // sequencer state
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state <= dse_pkg::DSE_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         armed <= 1'b0;
      end else begin
         armed <= next_armed;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         lock_enabled <= 1'b0;
      end else begin
         lock_enabled <= next_lock;
      end
   end

   // erase address, also the progress word
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         lba <= 28'h0000000;
      end else begin
         lba <= next_lba;
      end
   end

   // task-file status and error registers
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         drive_status <= dse_pkg::DSE_ST_READY;
         error_flags <= dse_pkg::DSE_ERR_NONE;
      end else begin
         drive_status <= next_status;
         error_flags <= next_error;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         frozen <= 1'b0;
      end else begin
         frozen <= next_frozen;
      end
   end

   // sector word counter, restarts on each command
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         word_idx <= 8'h00;
      end else if (new_cmd) begin
         word_idx <= 8'h00;
      end else if (word_in) begin
         word_idx <= word_idx + 8'h01;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctrl_word <= 16'h0000;
      end else if (ctrl_in) begin
         ctrl_word <= data_word;
      end
   end

   // zero-fill request stays up until the media acknowledges
   wire logic walk_req = (next_state == dse_pkg::DSE_ERASE) & ~wr_done;

   // media path writes user sectors only
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         zero_wr_valid <= 1'b0;
         zero_wr_lba <= 28'h0000000;
      end else begin
         zero_wr_valid <= walk_req;
         zero_wr_lba <= next_lba;
      end
   end

   // commands handled elsewhere go on; only format carries the arming seen
   wire logic fwd_take = new_cmd & ~frozen_reject & ~op_prepare & ~op_freeze & ~op_erase;
   // format right after prepare keeps the arming
   wire logic fwd_format_armed = armed & op_format;

   // forward strobe and arming flag
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         fwd_valid <= 1'b0;
         fwd_armed <= 1'b0;
      end else begin
         fwd_valid <= fwd_take;
         fwd_armed <= fwd_format_armed;
      end
   end

   // forwarded opcode
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         fwd_code <= 8'h00;
      end else begin
         fwd_code <= command_code;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ident_word89 <= 16'h0000;
      end else begin
         ident_word89 <= ERASE_TIME_WORD;
      end
   end

   // interrupt next values, set beats clear
   wire logic [3:0] clear_mask = wr_clear ? reg_wdata[3:0] : 4'h0;
   wire logic [3:0] next_int_status = (int_status & ~clear_mask) | events;
   wire logic [3:0] next_int_enable = wr_enable ? reg_wdata[3:0] : int_enable;

   // sticky event bits
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         int_status <= dse_pkg::DSE_INT_RESET;
      end else begin
         int_status <= next_int_status;
      end
   end

   // interrupt enable bits
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         int_enable <= dse_pkg::DSE_INT_RESET;
      end else begin
         int_enable <= next_int_enable;
      end
   end

   // level interrupt, same edge as the status bit
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(next_int_status & next_int_enable);
      end
   end

   // register read data, one cycle after the strobe
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         reg_rdata <= 32'h00000000;
      end else begin
         reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
      end
   end

endmodule

// [bench/dse_core_properties.sv]
// Purpose: port checks of the erase and freeze command block
// Assumes: one clock, synchronous active-high reset
// Notes: armed state rebuilt here from the command stream
`timescale 1ns/100ps
module dse_core_properties #(
   parameter logic [27:0] NATIVE_MAX_LBA = 28'h00fffff,
   parameter logic [15:0] ERASE_TIME_WORD = 16'h003c
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic cmd_wr,
   input wire logic [7:0] command_code,
   input wire logic [7:0] drive_status,
   input wire logic [7:0] error_flags,
   input wire logic zero_wr_valid,
   input wire logic [27:0] zero_wr_lba,
   input wire logic zero_wr_ack,
   input wire logic fwd_valid,
   input wire logic fwd_armed,
   input wire logic [15:0] ident_word89,
   input wire logic frozen,
   input wire logic lock_enabled
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic armed_q;
   // command decode while idle
   wire busy = drive_status == dse_pkg::DSE_ST_DRQ || drive_status == dse_pkg::DSE_ST_BUSY;
   wire taken = cmd_wr && !busy;
   wire t_prep = taken && command_code == dse_pkg::DSE_OP_PREPARE;
   wire t_erase = taken && command_code == dse_pkg::DSE_OP_ERASE;
   wire t_fmt = taken && command_code == dse_pkg::DSE_OP_FORMAT;
   wire guarded = t_erase || (taken && command_code inside {8'hf1, 8'hf2, 8'hf6});
   wire abrt = drive_status == dse_pkg::DSE_ST_ERROR && error_flags == dse_pkg::DSE_ERR_ABORT;
   wire last_sec = zero_wr_valid && zero_wr_ack && zero_wr_lba == NATIVE_MAX_LBA;
   // last taken command was prepare
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         armed_q <= 1'b0;
      end else if (taken) begin
         armed_q <= command_code == dse_pkg::DSE_OP_PREPARE;
      end
   end
   property p_prep; t_prep |=> drive_status == dse_pkg::DSE_ST_READY && error_flags == 8'h00; endproperty
   a_prep: assert property (p_prep) else $error("prepare not done at once");
   property p_noprep; t_erase && !armed_q |=> abrt; endproperty
   a_noprep: assert property (p_noprep) else $error("unarmed erase not aborted");
   property p_sector; t_erase && armed_q && !frozen |=> drive_status == dse_pkg::DSE_ST_DRQ; endproperty
   a_sector: assert property (p_sector) else $error("erase did not request sector");
   property p_rej; guarded && frozen |=> abrt; endproperty
   a_rej: assert property (p_rej) else $error("frozen command not rejected");
   property p_freeze; taken && command_code == dse_pkg::DSE_OP_FREEZE |=> frozen; endproperty
   a_freeze: assert property (p_freeze) else $error("freeze not entered");
   property p_stay; frozen |=> frozen; endproperty
   a_stay: assert property (p_stay) else $error("frozen state left");
   property p_start; drive_status == dse_pkg::DSE_ST_BUSY && $past(drive_status) == dse_pkg::DSE_ST_DRQ |->
      zero_wr_valid && zero_wr_lba == 28'h0000000; endproperty
   a_start: assert property (p_start) else $error("erase not started at lba 0");
   property p_hold; zero_wr_valid && !zero_wr_ack |=> zero_wr_valid && $stable(zero_wr_lba); endproperty
   a_hold: assert property (p_hold) else $error("zero-fill request dropped");
   property p_done; last_sec |=> drive_status == dse_pkg::DSE_ST_READY && !lock_enabled; endproperty
   a_done: assert property (p_done) else $error("erase end without lock off");
   property p_fwd; t_fmt |=> fwd_valid && fwd_armed == $past(armed_q); endproperty
   a_fwd: assert property (p_fwd) else $error("format arming wrong");
   property p_ident; !$past(rst) |-> ident_word89 == ERASE_TIME_WORD; endproperty
   a_ident: assert property (p_ident) else $error("erase time word wrong");
   c_erase: cover property (last_sec);
   c_rej: cover property (guarded && frozen);
   c_fmt: cover property (fwd_valid && fwd_armed);
endmodule
bind dse_core dse_core_properties #(.NATIVE_MAX_LBA(NATIVE_MAX_LBA), .ERASE_TIME_WORD(ERASE_TIME_WORD)) i_chk (
   .ref_clk, .rst, .cmd_wr, .command_code, .drive_status, .error_flags, .zero_wr_valid, .zero_wr_lba,
   .zero_wr_ack, .fwd_valid, .fwd_armed, .ident_word89, .frozen, .lock_enabled);

// [bench/dse_media_model.sv]
// Purpose: media end of the zero-fill handshake
// Assumes: request held until acknowledged
// Notes: slow mode adds wait cycles per sector
`timescale 1ns/100ps
module dse_media_model #(
   parameter logic [27:0] LAST = 28'h3
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic slow,
   input wire logic zero_wr_valid,
   input wire logic [27:0] zero_wr_lba,
   output logic zero_wr_ack,
   output logic [27:0] written,
   output logic order_bad
);
   logic [1:0] wait_cnt;
   // write-only media, lba climbs from 0
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         zero_wr_ack <= 1'b0;
         wait_cnt <= 2'h0;
         written <= 28'h0;
         order_bad <= 1'b0;
      end else if (zero_wr_ack || !zero_wr_valid) begin
         zero_wr_ack <= 1'b0;
         wait_cnt <= 2'h0;
      end else if (!slow || wait_cnt == 2'h3) begin
         zero_wr_ack <= 1'b1;
         written <= written + 28'h1;
         order_bad <= order_bad || zero_wr_lba != written % (LAST + 28'h1);
      end else begin
         wait_cnt <= wait_cnt + 2'h1;
      end
   end
endmodule

// [bench/tb_disk_security_erase_freeze.sv]
// Purpose: directed tests of the erase and freeze command block
// Assumes: media model answers zero-fill requests
// Notes: native max shortened so an erase writes four sectors
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; $display("ERROR %0t mismatch %h", $time, (a)); end end
module tb_disk_security_erase_freeze;
   logic ref_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, cmd_wr = 1'b0, data_wr = 1'b0, slow = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0, reg_rdata;
   logic [7:0] command_code = 8'h00, drive_status, error_flags, fwd_code;
   logic [15:0] data_word = 16'h0000, ident_word89;
   logic [255:0] user_pw, master_pw;
   logic [27:0] zero_wr_lba, written;
   logic zero_wr_valid, zero_wr_ack, fwd_valid, fwd_armed, frozen, lock_enabled, irq, order_bad;
   logic [7:0] ops [4] = '{8'hf1, 8'hf2, 8'hf6, 8'hf4};
   int bad_count = 0, checks = 0;
   dse_core #(.NATIVE_MAX_LBA(28'h3), .ERASE_TIME_WORD(16'h0123)) i_dut (.ref_clk, .rst, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .cmd_wr, .command_code, .data_wr, .data_word, .user_pw, .master_pw,
      .drive_status, .error_flags, .zero_wr_valid, .zero_wr_lba, .zero_wr_ack, .fwd_valid, .fwd_code,
      .fwd_armed, .ident_word89, .frozen, .lock_enabled, .irq);
   dse_media_model #(.LAST(28'h3)) i_media (.ref_clk, .rst, .slow, .zero_wr_valid, .zero_wr_lba, .zero_wr_ack,
      .written, .order_bad);
   // clock, 50 ns period
   always #25 ref_clk = ~ref_clk;
   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic reg_check(input logic [3:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      `CHK(reg_rdata, e)
   endtask
   task automatic cmd(input logic [7:0] c);
      @(posedge ref_clk);
      cmd_wr <= 1'b1;
      command_code <= c;
      @(posedge ref_clk);
      cmd_wr <= 1'b0;
      #1;
   endtask
   task automatic chk_st(input logic [7:0] s, input logic [7:0] e);
      `CHK(drive_status, s)
      `CHK(error_flags, e)
   endtask
   // prepare, erase, then one full parameter sector
   task automatic erase(input logic [15:0] ctrl, input logic [255:0] pw);
      cmd(dse_pkg::DSE_OP_PREPARE);
      cmd(dse_pkg::DSE_OP_ERASE);
      `CHK(drive_status, dse_pkg::DSE_ST_DRQ)
      for (int i = 0; i < 256; i++) begin
         @(posedge ref_clk);
         data_wr <= 1'b1;
         data_word <= (i == 0) ? ctrl : (i <= 16) ? pw[((i - 1) & 15) * 16 +: 16] : 16'hffff;
      end
      @(posedge ref_clk);
      data_wr <= 1'b0;
      #1;
   endtask
   task automatic wait_idle;
      int n = 0;
      while (drive_status === dse_pkg::DSE_ST_BUSY && n < 100) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      chk_st(dse_pkg::DSE_ST_READY, dse_pkg::DSE_ERR_NONE);
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // watchdog against a hung handshake
   initial begin
      #1000000;
      bad_count++;
      finish_test;
   end
   initial begin
      for (int i = 0; i < 16; i++) begin
         user_pw[i * 16 +: 16] = 16'h1100 + i;
         master_pw[i * 16 +: 16] = 16'h2200 + i;
      end
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      reg_check(dse_pkg::DSE_REG_STATE, 32'h0);
      reg_check(4'hf, 32'h0);
      `CHK(ident_word89, 16'h0123)
      reg_write(dse_pkg::DSE_REG_INT_ENABLE, 32'h3);
      cmd(dse_pkg::DSE_OP_ERASE);
      chk_st(dse_pkg::DSE_ST_ERROR, dse_pkg::DSE_ERR_ABORT);
      reg_check(dse_pkg::DSE_REG_INT_STATUS, 32'h2);
      `CHK(irq, 1'b1)
      reg_write(dse_pkg::DSE_REG_INT_CLEAR, 32'h2);
      reg_check(dse_pkg::DSE_REG_INT_STATUS, 32'h0);
      `CHK(irq, 1'b0)
      $display("test reset and abort done");
      cmd(dse_pkg::DSE_OP_PREPARE);
      chk_st(dse_pkg::DSE_ST_READY, dse_pkg::DSE_ERR_NONE);
      cmd(8'hf1);
      `CHK(fwd_valid, 1'b1)
      `CHK(fwd_code, 8'hf1)
      cmd(dse_pkg::DSE_OP_ERASE);
      chk_st(dse_pkg::DSE_ST_ERROR, dse_pkg::DSE_ERR_ABORT);
      cmd(dse_pkg::DSE_OP_PREPARE);
      cmd(dse_pkg::DSE_OP_FORMAT);
      `CHK(fwd_armed, 1'b1)
      `CHK(fwd_code, 8'h50)
      cmd(dse_pkg::DSE_OP_FORMAT);
      `CHK(fwd_armed, 1'b0)
      $display("test arming done");
      reg_write(dse_pkg::DSE_REG_CTRL, 32'h1);
      erase(16'h0000, master_pw);
      chk_st(dse_pkg::DSE_ST_ERROR, dse_pkg::DSE_ERR_ABORT);
      slow <= 1'b1;
      erase(16'h0001, master_pw);
      `CHK(drive_status, dse_pkg::DSE_ST_BUSY)
      wait_idle;
      `CHK(lock_enabled, 1'b0)
      `CHK(written, 28'h4)
      reg_check(dse_pkg::DSE_REG_INT_STATUS, 32'hb);
      reg_check(dse_pkg::DSE_REG_PROGRESS, 32'h3);
      reg_check(dse_pkg::DSE_REG_CTRL, 32'h0);
      erase(16'h0002, user_pw);
      chk_st(dse_pkg::DSE_ST_ERROR, dse_pkg::DSE_ERR_ABORT);
      slow <= 1'b0;
      erase(16'h0000, ~user_pw);
      `CHK(drive_status, dse_pkg::DSE_ST_BUSY)
      wait_idle;
      `CHK(written, 28'h8)
      `CHK(order_bad, 1'b0)
      $display("test erase done");
      reg_write(dse_pkg::DSE_REG_INT_ENABLE, 32'h0);
      reg_write(dse_pkg::DSE_REG_INT_CLEAR, 32'hf);
      cmd(dse_pkg::DSE_OP_FREEZE);
      `CHK(frozen, 1'b1)
      foreach (ops[k]) begin
         cmd(ops[k]);
         chk_st(dse_pkg::DSE_ST_ERROR, dse_pkg::DSE_ERR_ABORT);
      end
      cmd(dse_pkg::DSE_OP_PREPARE);
      cmd(dse_pkg::DSE_OP_ERASE);
      chk_st(dse_pkg::DSE_ST_ERROR, dse_pkg::DSE_ERR_ABORT);
      reg_check(dse_pkg::DSE_REG_INT_STATUS, 32'he);
      `CHK(irq, 1'b0)
      `CHK(frozen, 1'b1)
      reg_check(dse_pkg::DSE_REG_STATE, 32'h1);
      // power cycle: only a reset leaves the frozen state
      @(posedge ref_clk);
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      reg_check(dse_pkg::DSE_REG_STATE, 32'h0);
      `CHK(frozen, 1'b0)
      $display("test freeze done");
      finish_test;
   end
endmodule
